//--- rtl/ssd_pkg.sv
// shared constants for the setup-stage state packet link
package ssd_pkg;
	// header fields
	localparam logic [2:0] SSD_CMD_TYPE       = 3'h3;
	localparam logic [1:0] SSD_CMD_SUBTYPE    = 2'h3;
	localparam logic [2:0] SSD_CMD_OPCODE     = 3'h0;
	localparam logic [7:0] SSD_CMD_SUBOPCODE  = 8'h13;
	localparam logic [7:0] SSD_LEN_DEFAULT    = 8'h12;
	localparam int         SSD_TYPE_MSB       = 31;
	localparam int         SSD_TYPE_LSB       = 29;
	localparam int         SSD_SUBTYPE_MSB    = 28;
	localparam int         SSD_SUBTYPE_LSB    = 27;
	localparam int         SSD_OPC_MSB        = 26;
	localparam int         SSD_OPC_LSB        = 24;
	localparam int         SSD_SUBOPC_MSB     = 23;
	localparam int         SSD_SUBOPC_LSB     = 16;
	localparam int         SSD_LEN_MSB        = 7;
	localparam int         SSD_LEN_LSB        = 0;
	// dword 1 fields
	localparam int         SSD_NATTR_MSB      = 27;
	localparam int         SSD_NATTR_LSB      = 22;
	localparam int         SSD_SWZ_EN_BIT     = 21;
	localparam int         SSD_SPRITE_ORG_BIT = 20;
	localparam int         SSD_RDLEN_MSB      = 15;
	localparam int         SSD_RDLEN_LSB      = 11;
	localparam int         SSD_RDOFS_MSB      = 9;
	localparam int         SSD_RDOFS_LSB      = 4;
	// dword 2 fields
	localparam int         SSD_STATS_BIT      = 10;
	localparam int         SSD_DOFS_SOLID_BIT = 9;
	localparam int         SSD_DOFS_WIRE_BIT  = 8;
	localparam int         SSD_DOFS_POINT_BIT = 7;
	localparam int         SSD_FRONT_MSB      = 6;
	localparam int         SSD_FRONT_LSB      = 5;
	localparam int         SSD_BACK_MSB       = 4;
	localparam int         SSD_BACK_LSB       = 3;
	// dword 3 fields
	localparam int         SSD_AADIST_BIT     = 14;
	localparam int         SSD_SPRITE_PT_BIT  = 13;
	localparam int         SSD_SUBPIX_BIT     = 12;
	localparam int         SSD_PTW_SRC_BIT    = 11;
	localparam int         SSD_PTW_MSB        = 10;
	localparam int         SSD_PTW_LSB        = 0;
	// attribute count bands
	localparam logic [5:0] SSD_ATTR_SWZ_MAX   = 6'd16;
	localparam logic [5:0] SSD_ATTR_FWD_MAX   = 6'd32;
	localparam logic [5:0] SSD_ATTR_HI_BIAS   = 6'd16;
	// subpixel fraction bits
	localparam logic [3:0] SSD_SUBPIX_FINE    = 4'h8;
	localparam logic [3:0] SSD_SUBPIX_COARSE  = 4'h4;
	// apb register offsets of the streamer
	localparam logic [7:0] SSD_REG_CTRL       = 8'h00;
	localparam logic [7:0] SSD_REG_LEN        = 8'h04;
	localparam logic [7:0] SSD_REG_DW1        = 8'h08;
	localparam logic [7:0] SSD_REG_DW2        = 8'h0c;
	localparam logic [7:0] SSD_REG_DW3        = 8'h10;
	localparam logic [7:0] SSD_REG_STATUS     = 8'h14;
	localparam logic [31:0] SSD_DW_RESET      = 32'h0;
	// fill modes
	typedef enum logic [1:0] {
		SSD_FILL_SOLID = 2'h0,
		SSD_FILL_WIRE  = 2'h1,
		SSD_FILL_POINT = 2'h2,
		SSD_FILL_RSVD  = 2'h3
	} ssd_fill_e;
endpackage : ssd_pkg

//--- rtl/ssd_link_if.sv
// dword stream link between command streamer and setup-stage decoder
`timescale 1ns/100ps
`default_nettype none
interface ssd_link_if;
	logic        dw_valid;
	logic        dw_ready;
	logic [31:0] dw_data;

	modport streamer (output dw_valid, output dw_data, input dw_ready);
	modport decoder  (input dw_valid, input dw_data, output dw_ready);
endinterface : ssd_link_if
`default_nettype wire

//--- rtl/ssd_decoder.sv
// setup-stage state packet decoder and derived controls
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - header type 3, subtype 3, opcode 0, sub 13h
// - length field is total dwords minus two
// - attribute count in dword1 bits 27:22
// - count 1-16 swizzles attributes 0-15
// - count 17-32 forwards attributes 16-31 unchanged
// - count 33-48 outputs count-16, overrides act high
// - swizzle disable passes all attributes unmodified
// - bit 20 picks sprite texture origin
// - read length 1-16 units, zero undefined
// - read offset 0-63 units
// - statistics enable counts clipper primitives
// - software sets stats with clipping stats
// - three depth offset enables per fill
// - front fill mode solid/wire/point
// - back fill mode same encoding
// - rectangle lists need solid fill both faces
// - wire/point emission gated by edge flags
// - bit 14 selects true line distance
// - sprite point hint copied to payload
// - bit 12 selects 8 or 4 fraction bits
// - bit 11 selects point width source
// - point width U8.3, vertex width overrides
module ssd_decoder
	import ssd_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	ssd_link_if.decoder      link,
	output logic             pkt_done,
	output logic             pkt_foreign,
	output logic [5:0]       attr_out_count,
	output logic [15:0]      attr_swz_lo,
	output logic [15:0]      attr_ovr_hi,
	output logic [15:0]      attr_wrap_lo,
	output logic             sprite_origin_bottom,
	output logic [4:0]       return_read_length,
	output logic [5:0]       return_read_offset,
	output logic             stats_enable,
	input  wire logic        clip_prim_event,
	output logic [31:0]      clipper_primitive_counter,
	output ssd_fill_e        front_fill,
	output ssd_fill_e        back_fill,
	input  wire logic        tri_back_facing,
	input  wire logic [2:0]  per_vertex_edge_flags,
	output logic             draw_solid,
	output logic [2:0]       draw_edges,
	output logic [2:0]       draw_points,
	output logic             depth_offset_apply,
	output logic             true_line_distance,
	output logic             sprite_point_hint,
	output logic [3:0]       subpixel_bits,
	output logic             point_width_from_state,
	output logic [10:0]      point_width,
	input  wire logic [10:0] vertex_point_width,
	input  wire logic [1:0]  sprite_corner,
	output logic [1:0]       sprite_coord
);
	typedef enum logic [2:0] {
		SSD_ST_HDR, SSD_ST_DW1, SSD_ST_DW2, SSD_ST_DW3, SSD_ST_SKIP
	} ssd_state_e;

	ssd_state_e  state_reg;
	logic [8:0]  remain_reg;
	logic        accept;
	logic        hdr_match;
	logic [31:0] dw1_reg;
	logic [31:0] dw2_reg;
	logic [31:0] dw3_reg;
	logic [5:0]  nattr;
	ssd_fill_e   face_fill;

	// always ready; the decoder never stalls the stream
	assign link.dw_ready = 1'b1;
	assign accept        = link.dw_valid;

	// exact command match
	assign hdr_match =
		link.dw_data[SSD_TYPE_MSB:SSD_TYPE_LSB] == SSD_CMD_TYPE &&
		link.dw_data[SSD_SUBTYPE_MSB:SSD_SUBTYPE_LSB] == SSD_CMD_SUBTYPE &&
		link.dw_data[SSD_OPC_MSB:SSD_OPC_LSB] == SSD_CMD_OPCODE &&
		link.dw_data[SSD_SUBOPC_MSB:SSD_SUBOPC_LSB] == SSD_CMD_SUBOPCODE;

	// packet walker; remain counts dwords still to come after the current one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= SSD_ST_HDR;
			remain_reg <= 9'h0;
		end else if (accept) begin
			unique case (state_reg)
				SSD_ST_HDR: begin
					remain_reg <= {1'b0, link.dw_data[SSD_LEN_MSB:SSD_LEN_LSB]}
						+ 9'h0;
					state_reg  <= hdr_match ? SSD_ST_DW1 : SSD_ST_SKIP;
				end
				SSD_ST_DW1, SSD_ST_DW2, SSD_ST_DW3, SSD_ST_SKIP: begin
					remain_reg <= remain_reg - 9'h1;
					if (remain_reg == 9'h0)
						state_reg <= SSD_ST_HDR;
					else if (state_reg == SSD_ST_DW1)
						state_reg <= SSD_ST_DW2;
					else if (state_reg == SSD_ST_DW2)
						state_reg <= SSD_ST_DW3;
					else
						state_reg <= SSD_ST_SKIP;
				end
			endcase
		end
	end

	// field capture; reserved bits kept but never used
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dw1_reg <= SSD_DW_RESET;
			dw2_reg <= SSD_DW_RESET;
			dw3_reg <= SSD_DW_RESET;
		end else if (accept) begin
			if (state_reg == SSD_ST_DW1)
				dw1_reg <= link.dw_data;
			if (state_reg == SSD_ST_DW2)
				dw2_reg <= link.dw_data;
			if (state_reg == SSD_ST_DW3)
				dw3_reg <= link.dw_data;
		end
	end

	// end-of-packet and foreign-header pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pkt_done    <= 1'b0;
			pkt_foreign <= 1'b0;
		end else begin
			pkt_done    <= accept && state_reg != SSD_ST_HDR &&
				remain_reg == 9'h0;
			pkt_foreign <= accept && state_reg == SSD_ST_HDR && !hdr_match;
		end
	end

	// clipper primitive counter on the clipper's behalf
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			clipper_primitive_counter <= 32'h0;
		else if (clip_prim_event && dw2_reg[SSD_STATS_BIT])
			clipper_primitive_counter <= clipper_primitive_counter + 32'h1;
	end

	assign nattr = dw1_reg[SSD_NATTR_MSB:SSD_NATTR_LSB];

	// attribute band decode
	always_comb begin
		attr_out_count = nattr;
		attr_swz_lo    = 16'h0;
		attr_ovr_hi    = 16'h0;
		attr_wrap_lo   = 16'h0;
		if (dw1_reg[SSD_SWZ_EN_BIT] && nattr != 6'd0) begin
			if (nattr <= SSD_ATTR_SWZ_MAX) begin
				attr_swz_lo  = 16'hffff >> (SSD_ATTR_SWZ_MAX - nattr);
				attr_wrap_lo = attr_swz_lo;
			end else if (nattr <= SSD_ATTR_FWD_MAX) begin
				attr_swz_lo  = 16'hffff;
				attr_wrap_lo = 16'hffff;
			end else begin
				attr_ovr_hi  = 16'hffff >>
					(SSD_ATTR_FWD_MAX + SSD_ATTR_HI_BIAS - nattr);
				attr_wrap_lo = 16'hffff;
			end
		end
		if (nattr > SSD_ATTR_FWD_MAX)
			attr_out_count = nattr - SSD_ATTR_HI_BIAS;
	end

	assign sprite_origin_bottom = dw1_reg[SSD_SPRITE_ORG_BIT];
	assign return_read_length = dw1_reg[SSD_RDLEN_MSB:SSD_RDLEN_LSB];
	assign return_read_offset = dw1_reg[SSD_RDOFS_MSB:SSD_RDOFS_LSB];
	assign stats_enable    = dw2_reg[SSD_STATS_BIT];

	// sprite corner: 0 tl, 1 bl, 2 br, 3 tr; coord is {s,t}
	always_comb begin
		sprite_coord[1] = sprite_corner[1];
		sprite_coord[0] = (sprite_corner == 2'd1 || sprite_corner == 2'd2)
			^ dw1_reg[SSD_SPRITE_ORG_BIT];
	end

	assign front_fill = ssd_fill_e'(dw2_reg[SSD_FRONT_MSB:SSD_FRONT_LSB]);
	assign back_fill  = ssd_fill_e'(dw2_reg[SSD_BACK_MSB:SSD_BACK_LSB]);
	assign face_fill  = tri_back_facing ? back_fill : front_fill;

	// fill emission and depth offset selection
	always_comb begin
		draw_solid         = 1'b0;
		draw_edges         = 3'h0;
		draw_points        = 3'h0;
		depth_offset_apply = 1'b0;
		unique case (face_fill)
			SSD_FILL_SOLID: begin
				draw_solid         = 1'b1;
				depth_offset_apply = dw2_reg[SSD_DOFS_SOLID_BIT];
			end
			SSD_FILL_WIRE: begin
				draw_edges         = per_vertex_edge_flags;
				depth_offset_apply = dw2_reg[SSD_DOFS_WIRE_BIT];
			end
			SSD_FILL_POINT: begin
				draw_points        = per_vertex_edge_flags;
				depth_offset_apply = dw2_reg[SSD_DOFS_POINT_BIT];
			end
			SSD_FILL_RSVD: begin
				draw_solid         = 1'b0; // reserved draws nothing
			end
		endcase
	end

	assign true_line_distance = dw3_reg[SSD_AADIST_BIT];
	assign sprite_point_hint  = dw3_reg[SSD_SPRITE_PT_BIT];
	assign subpixel_bits = dw3_reg[SSD_SUBPIX_BIT] ?
		SSD_SUBPIX_COARSE : SSD_SUBPIX_FINE;
	assign point_width_from_state = dw3_reg[SSD_PTW_SRC_BIT];
	// stored width stays; vertex width only overrides the used value
	assign point_width = dw3_reg[SSD_PTW_SRC_BIT] ?
		dw3_reg[SSD_PTW_MSB:SSD_PTW_LSB] : vertex_point_width;
endmodule : ssd_decoder
`default_nettype wire

//--- rtl/ssd_streamer.sv
// command streamer end: apb registers drive one state packet out
`timescale 1ns/100ps
`default_nettype none
module ssd_streamer
	import ssd_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	ssd_link_if.streamer     link
);
	logic [7:0]  len_reg;
	logic [31:0] dw1_reg;
	logic [31:0] dw2_reg;
	logic [31:0] dw3_reg;
	logic        busy_reg;
	logic [8:0]  idx_reg;
	logic [15:0] sent_reg;
	logic        wr;
	logic        start;
	logic        mapped;
	logic [31:0] hdr;

	// zero-wait apb slave
	assign pready = 1'b1;
	assign wr     = psel && penable && pwrite;
	assign start  = wr && paddr == SSD_REG_CTRL && pwdata[0] && !busy_reg;
	assign mapped = paddr == SSD_REG_CTRL || paddr == SSD_REG_LEN ||
		paddr == SSD_REG_DW1 || paddr == SSD_REG_DW2 ||
		paddr == SSD_REG_DW3 || paddr == SSD_REG_STATUS;
	assign pslverr = psel && penable && !mapped;

	// register writes; packet words frozen while busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			len_reg <= SSD_LEN_DEFAULT;
			dw1_reg <= SSD_DW_RESET;
			dw2_reg <= SSD_DW_RESET;
			dw3_reg <= SSD_DW_RESET;
		end else if (wr && !busy_reg) begin
			if (paddr == SSD_REG_LEN)
				len_reg <= pwdata[7:0];
			if (paddr == SSD_REG_DW1)
				dw1_reg <= pwdata;
			if (paddr == SSD_REG_DW2)
				dw2_reg <= pwdata;
			if (paddr == SSD_REG_DW3)
				dw3_reg <= pwdata;
		end
	end

	// read mux
	always_comb begin
		prdata = 32'h0;
		unique case (paddr)
			SSD_REG_LEN:    prdata = {24'h0, len_reg};
			SSD_REG_DW1:    prdata = dw1_reg;
			SSD_REG_DW2:    prdata = dw2_reg;
			SSD_REG_DW3:    prdata = dw3_reg;
			SSD_REG_STATUS: prdata = {sent_reg, 15'h0, busy_reg};
			default:        prdata = 32'h0;
		endcase
	end

	// header built from fixed codes plus length
	assign hdr = {SSD_CMD_TYPE, SSD_CMD_SUBTYPE, SSD_CMD_OPCODE,
		SSD_CMD_SUBOPCODE, 8'h0, len_reg};

	// sequencer: len+2 dwords, trailing ones zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
			idx_reg  <= 9'h0;
			sent_reg <= 16'h0;
		end else if (start) begin
			busy_reg <= 1'b1;
			idx_reg  <= 9'h0;
		end else if (busy_reg && link.dw_ready) begin
			idx_reg <= idx_reg + 9'h1;
			if (idx_reg == {1'b0, len_reg} + 9'h1) begin
				busy_reg <= 1'b0;
				sent_reg <= sent_reg + 16'h1;
			end
		end
	end

	assign link.dw_valid = busy_reg;
	always_comb begin
		unique case (idx_reg)
			9'h0:    link.dw_data = hdr;
			9'h1:    link.dw_data = dw1_reg;
			9'h2:    link.dw_data = dw2_reg;
			9'h3:    link.dw_data = dw3_reg;
			default: link.dw_data = 32'h0;
		endcase
	end
endmodule : ssd_streamer
`default_nettype wire

//--- testbench/ssd_link_properties.sv
// link protocol checks between streamer and decoder
`timescale 1ns/100ps
`default_nettype none
module ssd_link_properties
	import ssd_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        dw_valid,
	input wire logic        dw_ready,
	input wire logic [31:0] dw_data
);
	logic [8:0] idx_reg;
	logic [7:0] len_reg;
	logic       last;

	// last word of the packet in flight
	assign last = (idx_reg != 9'h0) && (idx_reg == {1'b0, len_reg} + 9'h1);

	// word position within the packet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_reg <= 9'h0;
		end else if (dw_valid && dw_ready) begin
			idx_reg <= last ? 9'h0 : idx_reg + 9'h1;
		end
	end

	// length field of the header in flight
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			len_reg <= 8'h0;
		end else if (dw_valid && idx_reg == 9'h0) begin
			len_reg <= dw_data[SSD_LEN_MSB:SSD_LEN_LSB];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_always_high: assert property (dw_ready)
		else $error("link ready dropped");
	a_header_type_ok: assert property (dw_valid && idx_reg == 9'h0 |->
		dw_data[SSD_TYPE_MSB:SSD_SUBTYPE_LSB] == {SSD_CMD_TYPE, SSD_CMD_SUBTYPE})
		else $error("header type wrong");
	a_header_opcode_ok: assert property (dw_valid && idx_reg == 9'h0 |->
		dw_data[SSD_OPC_MSB:SSD_SUBOPC_LSB] == {SSD_CMD_OPCODE, SSD_CMD_SUBOPCODE})
		else $error("header opcode wrong");
	a_header_rsvd_zero: assert property (dw_valid && idx_reg == 9'h0 |->
		dw_data[15:8] == 8'h0)
		else $error("header reserved bits set");
	a_frame_starts_header: assert property ($rose(dw_valid) |-> idx_reg == 9'h0)
		else $error("packet started mid count");
	a_burst_no_gap: assert property (dw_valid && !last |=> dw_valid)
		else $error("gap inside packet");
	a_frame_ends_len: assert property (dw_valid && last |=> !dw_valid)
		else $error("packet longer than length field");
	a_frame_bounded: assert property ($rose(dw_valid) |-> ##[1:258] !dw_valid)
		else $error("packet never ended");
	a_tail_words_zero: assert property (dw_valid && idx_reg > 9'h3 |->
		dw_data == 32'h0)
		else $error("tail word not zero");
endmodule : ssd_link_properties
`default_nettype wire

//--- testbench/tb_setup_stage_state_decoder.sv
// self-checking bench for the streamer and decoder pair
`timescale 1ns/100ps
`default_nettype none
module tb_setup_stage_state_decoder
	import ssd_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r, c0;
	logic        pkt_done, pkt_foreign, sprite_origin_bottom, stats_enable;
	logic        clip_prim_event, tri_back_facing, draw_solid;
	logic        depth_offset_apply, true_line_distance, sprite_point_hint;
	logic        point_width_from_state;
	logic [5:0]  attr_out_count, return_read_offset;
	logic [15:0] attr_swz_lo, attr_ovr_hi, attr_wrap_lo;
	logic [4:0]  return_read_length;
	logic [31:0] clipper_primitive_counter;
	ssd_fill_e   front_fill, back_fill;
	logic [2:0]  per_vertex_edge_flags, draw_edges, draw_points;
	logic [3:0]  subpixel_bits;
	logic [10:0] point_width, vertex_point_width;
	logic [1:0]  sprite_corner, sprite_coord;
	int          failures, comparisons, cycles, npk, i, s, n, f, b, m, k, c;
	int          counts[7] = '{0, 5, 16, 17, 32, 33, 48};
	logic [2:0]  dofs;
	int          ndone, nforeign;

	ssd_link_if ssd_link_if_inst();
	ssd_streamer ssd_streamer_inst(.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .link(ssd_link_if_inst));
	ssd_decoder ssd_decoder_inst(.pclk, .presetn, .link(ssd_link_if_inst),
		.pkt_done, .pkt_foreign, .attr_out_count, .attr_swz_lo, .attr_ovr_hi,
		.attr_wrap_lo, .sprite_origin_bottom, .return_read_length,
		.return_read_offset, .stats_enable, .clip_prim_event,
		.clipper_primitive_counter, .front_fill, .back_fill, .tri_back_facing,
		.per_vertex_edge_flags, .draw_solid, .draw_edges, .draw_points,
		.depth_offset_apply, .true_line_distance, .sprite_point_hint,
		.subpixel_bits, .point_width_from_state, .point_width,
		.vertex_point_width, .sprite_corner, .sprite_coord);
	ssd_link_properties ssd_link_properties_inst(.pclk, .presetn,
		.dw_valid(ssd_link_if_inst.dw_valid), .dw_ready(ssd_link_if_inst.dw_ready),
		.dw_data(ssd_link_if_inst.dw_data));

	// 25 MHz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// verdict and end of run
	task automatic complete_run;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	// one comparison
	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, x, g);
		end
	endtask : chk

	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// load the three field words and send one packet
	task automatic send(input logic [31:0] d1, input logic [31:0] d2,
		input logic [31:0] d3);
		int j;
		apb(1'b1, SSD_REG_DW1, d1);
		apb(1'b1, SSD_REG_DW2, d2);
		apb(1'b1, SSD_REG_DW3, d3);
		apb(1'b1, SSD_REG_CTRL, 32'h1);
		npk++;
		for (j = 0; j < 60 && pkt_done !== 1'b1; j++) @(negedge pclk);
		chk("pkt_done", 1, pkt_done);
	endtask : send

	// decoder pulse counts, sampled mid-cycle
	always @(negedge pclk) begin
		if (pkt_done === 1'b1) ndone++;
		if (pkt_foreign === 1'b1) nforeign++;
	end

	// hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 8000) begin
			failures++;
			complete_run;
		end
	end

	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, clip_prim_event, tri_back_facing} = 6'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		per_vertex_edge_flags = 3'h5;
		vertex_point_width = 11'h2a5;
		sprite_corner = 2'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, SSD_REG_LEN, 32'h0);
		chk("len", 32'h12, r);
		chk("pslverr", 0, e);
		chk("front", SSD_FILL_SOLID, front_fill);
		chk("subpix", 4'h8, subpixel_bits);
		apb(1'b0, 8'h3c, 32'h0);
		chk("pslverr", 1, e);
		for (i = 0; i < 7; i++) for (s = 0; s < 2; s++) begin
			n = counts[i];
			send({4'h0, n[5:0], s[0], i[0], 4'h0, 5'(i + 1), 1'b0,
				6'(63 - i), 4'h0}, 0, 0);
			chk("cnt", n > 32 ? n - 16 : n, attr_out_count);
			chk("swz", (!s || n == 0) ? 0 : n <= 16 ? (1 << n) - 1 :
				n <= 32 ? 32'hffff : 0, attr_swz_lo);
			chk("wrap", (!s || n == 0) ? 0 :
				n <= 16 ? (1 << n) - 1 : 32'hffff, attr_wrap_lo);
			chk("ovr", (s && n > 32) ? (1 << (n - 32)) - 1 : 0,
				attr_ovr_hi);
			chk("org", i[0], sprite_origin_bottom);
			chk("rdlen", i + 1, return_read_length);
			chk("rdofs", 63 - i, return_read_offset);
		end
		for (f = 0; f < 4; f++) begin
			b = 3 - f;
			dofs = 3'b101 ^ {3{f[0]}};
			send(0, {22'h0, dofs, f[1:0], b[1:0], 3'h0}, 0);
			for (k = 0; k < 2; k++) begin
				@(posedge pclk) tri_back_facing <= k[0];
				@(negedge pclk);
				m = k ? b : f;
				chk("ffill", f, front_fill);
				chk("bfill", b, back_fill);
				chk("solid", m == 0, draw_solid);
				chk("edges", m == 1 ? 5 : 0, draw_edges);
				chk("points", m == 2 ? 5 : 0, draw_points);
				chk("dofs", m == 3 ? 0 : dofs[2 - m], depth_offset_apply);
			end
		end
		for (k = 1; k >= 0; k--) begin
			send(0, k << 10, 0);
			chk("stats", k, stats_enable);
			c0 = clipper_primitive_counter;
			@(posedge pclk) clip_prim_event <= 1'b1;
			repeat (3) @(posedge pclk);
			clip_prim_event <= 1'b0;
			@(negedge pclk);
			chk("clipcnt", c0 + 3 * k, clipper_primitive_counter);
		end
		for (k = 0; k < 2; k++) begin
			send(k << 20, 0, k ? 32'h7fff : 32'h1);
			chk("aadist", k, true_line_distance);
			chk("hint", k, sprite_point_hint);
			chk("subpix", k ? 4 : 8, subpixel_bits);
			chk("wsrc", k, point_width_from_state);
			chk("width", k ? 11'h7ff : 11'h2a5, point_width);
			for (c = 0; c < 4; c++) begin
				@(posedge pclk) sprite_corner <= c[1:0];
				@(negedge pclk);
				// {s,t} per corner tl, bl, br, tr, two bits each from bit 0
				chk("coord", 2'((k ? 8'he1 : 8'hb4) >> (2 * c)), sprite_coord);
			end
		end
		// short packet: header, dword1, dword2; dword3 fields persist
		apb(1'b1, SSD_REG_LEN, 32'h1);
		apb(1'b0, SSD_REG_LEN, 32'h0);
		chk("len", 32'h1, r);
		send(32'h0, 32'h0, 32'h0);
		chk("width", 11'h7ff, point_width);
		chk("aadist", 1, true_line_distance);
		chk("org", 0, sprite_origin_bottom);
		apb(1'b1, SSD_REG_LEN, {24'h0, SSD_LEN_DEFAULT});
		send(32'h0, 32'h0, 32'h0);
		chk("width", 11'h2a5, point_width);
		apb(1'b0, SSD_REG_STATUS, 32'h0);
		chk("sent", npk, r[31:16]);
		chk("busy", 0, r[0]);
		chk("done", npk, ndone);
		chk("foreign", 0, nforeign);
		complete_run;
	end
endmodule : tb_setup_stage_state_decoder
`default_nettype wire
